// File: hdl/ifpb_defs.svh
// Purpose: offsets, field positions, reset values for the flag bank
// Assumes: 32-bit classic Wishbone, registers in the low byte lane
// Notes: reserved bits read as zero
//
// How it works
// - pin 2 priority bit 7, pin 1 bit 6; one is high priority
// - pin 2 enable bit 4, pin 1 enable bit 3; one allows it
// - pin event sets flag bit 1 or 0 until software writes zero
// - every flag sets on its event whatever the enable bits say
// - pin control bits 5 and 2, flag two bit 5 read zero
// - parallel port flag bit 7 sets on port access, software clears
// - conversion done flag bit 6 sets on conversion end, software clears
// - serial receive flag bit 5 read-only, clears on buffer read
// - serial transmit flag bit 4 read-only, clears on buffer write
// - sync serial flag bit 3 sets on transfer done, software clears
// - capture/compare flags set on capture or match, unused in pwm
// - timer flags set on match or overflow, cleared by software only
// - oscillator fail flag bit 7 sets on failover, software clears
// - comparator flag bit 6 sets on input change, software clears
// - memory write done flag bit 4 sets, software clears
// - bus collision flag bit 3 sets on collision, software clears
// - voltage detect flag bit 2 sets on trip, software clears
// - flag three bits 7,6,5: invalid message, wake activity, error
// - mode 0: bits 4,3,2 flag transmit buffers 2,1,0 done
// - modes 1,2: bit 4 any transmit done, bits 3,2 held zero
// - receive bits per buffer in mode 0, aggregate else, watermark in modes 2 and 3 only
// - global enable gates all, both high and low priority with levels
// - edge select one picks rising edge, zero falling edge
// - without levels peripherals also need the group enable
`ifndef IFPB_DEFS_SVH
`define IFPB_DEFS_SVH

// register byte addresses
`define IFPB_ADR_PINCTL 8'h00
`define IFPB_ADR_FLAG1 8'h04
`define IFPB_ADR_FLAG2 8'h08
`define IFPB_ADR_FLAG3 8'h0C
`define IFPB_ADR_EN1 8'h10
`define IFPB_ADR_EN2 8'h14
`define IFPB_ADR_EN3 8'h18
`define IFPB_ADR_PRIO1 8'h1C
`define IFPB_ADR_PRIO2 8'h20
`define IFPB_ADR_PRIO3 8'h24
`define IFPB_ADR_GCTL 8'h28
`define IFPB_ADR_STAT 8'h2C

// pin control fields
`define IFPB_PIN2_PRIO 7
`define IFPB_PIN1_PRIO 6
`define IFPB_PIN2_EN 4
`define IFPB_PIN1_EN 3
`define IFPB_PIN2_FLAG 1
`define IFPB_PIN1_FLAG 0
`define IFPB_PINCTL_MASK 8'hDB
`define IFPB_PINCTL_RST 8'hC0

// flag register fields
`define IFPB_F1_PSP 7
`define IFPB_F1_RX 5
`define IFPB_F1_TX 4
`define IFPB_F1_CCP 2
`define IFPB_F1_RO_MASK 8'h30
`define IFPB_F2_MASK 8'hDF
`define IFPB_F3_TX1 3
`define IFPB_F3_TX0 2

// global control fields
`define IFPB_G_GIE 7
`define IFPB_G_PERIPHERAL_GROUP_ENABLE 6
`define IFPB_G_EDGE1 5
`define IFPB_G_EDGE2 4
`define IFPB_G_PRIORITY_LEVELS_ENABLE 3
`define IFPB_GCTL_MASK 8'hFB
`define IFPB_GCTL_RST 8'h30

`endif

// File: hdl/ifpb_pkg.sv
// Purpose: types of the interrupt flag and priority bank
// Assumes: constants live in ifpb_defs.svh
// Notes: whole module state is one packed struct
package ifpb_pkg;

  // operating mode of the CAN flag layout
  typedef enum logic [1:0] {
    CAN_LEGACY,
    CAN_ENHANCED,
    CAN_FIFO,
    CAN_RSVD
  } ifpb_can_mode_type;

  typedef struct packed {
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic [1:0] pin_prev;
    logic [7:0] pinctl;
    logic [7:0] flag1;
    logic [7:0] flag2;
    logic [7:0] flag3;
    logic [7:0] en1;
    logic [7:0] en2;
    logic [7:0] en3;
    logic [7:0] prio1;
    logic [7:0] prio2;
    logic [7:0] prio3;
    logic [7:0] gctl;
    ifpb_can_mode_type can_mode;
    logic ack;
    logic [7:0] dat;
    logic irq_high;
    logic irq_low;
  } ifpb_state_type;

endpackage

// File: hdl/ifpb_top.sv
// Purpose: interrupt flags, enables and priority routing
// Assumes: event inputs are one-cycle pulses on clk; pins are async
// Notes: set by an event wins over a software clear in the same edge
//
// Our own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`include "ifpb_defs.svh"

module ifpb_top (
  input wire logic clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pin1_irq_in,
  input wire logic pin2_irq_in,
  input wire logic psp_access_evt,
  input wire logic adc_done_evt,
  input wire logic rx_load_evt,
  input wire logic rx_buf_read,
  input wire logic tx_empty_evt,
  input wire logic tx_buf_write,
  input wire logic ssp_done_evt,
  input wire logic ccp1_evt,
  input wire logic ccp1_pwm_mode,
  input wire logic tmr2_match_evt,
  input wire logic tmr1_ovf_evt,
  input wire logic osc_fail_evt,
  input wire logic cmp_change_evt,
  input wire logic nv_write_evt,
  input wire logic bus_coll_evt,
  input wire logic volt_trip_evt,
  input wire logic tmr3_ovf_evt,
  input wire logic eccp_evt,
  input wire logic eccp_pwm_mode,
  input wire logic can_invalid_evt,
  input wire logic can_wake_evt,
  input wire logic can_err_evt,
  input wire logic [2:0] can_tx_done_evt,
  input wire logic [1:0] can_rx_new_evt,
  input wire logic can_watermark_evt,
  output logic irq_high,
  output logic irq_low
);

  ifpb_pkg::ifpb_state_type r_r;
  ifpb_pkg::ifpb_state_type r_nxt;

  logic req;
  logic wr_en;
  logic [7:0] wd;
  logic [7:0] adr;
  logic [1:0] edge_det;
  logic [7:0] ev1;
  logic [7:0] ev2;
  logic [7:0] ev3;
  logic [7:0] mask3;
  ifpb_pkg::ifpb_can_mode_type mode_nxt;
  logic [7:0] rdat;
  logic [1:0] pin_act;
  logic [7:0] act1;
  logic [7:0] act2;
  logic [7:0] act3;
  logic any_pin;
  logic any_per;
  logic any_high;
  logic any_low;

  // ------------------------------------------------------------
  // outputs straight from the state register
  // ------------------------------------------------------------
  assign wb_dat_o = {24'h000000, r_r.dat};
  assign wb_ack_o = r_r.ack;
  assign irq_high = r_r.irq_high;
  assign irq_low = r_r.irq_low;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  // write takes effect on the edge that sees ack high, read data is taken on the edge before
  assign req = wb_cyc_i & wb_stb_i;
  assign wr_en = req & wb_we_i & r_r.ack & wb_sel_i[0];
  assign wd = wb_dat_i[7:0];
  assign adr = {wb_adr_i[7:2], 2'b00};
  // mode standing after this edge, so a switch masks flag three at once
  assign mode_nxt = (wr_en && adr == `IFPB_ADR_GCTL) ?
                    ifpb_pkg::ifpb_can_mode_type'(wd[1:0]) : r_r.can_mode;

  // ------------------------------------------------------------
  // pin edge detection
  // ------------------------------------------------------------
  // edge select picks polarity
  always_comb
  begin
    edge_det[0] = r_r.gctl[`IFPB_G_EDGE1] ?
      (r_r.pin_s2[0] & ~r_r.pin_prev[0]) :
      (~r_r.pin_s2[0] & r_r.pin_prev[0]);
    edge_det[1] = r_r.gctl[`IFPB_G_EDGE2] ?
      (r_r.pin_s2[1] & ~r_r.pin_prev[1]) :
      (~r_r.pin_s2[1] & r_r.pin_prev[1]);
  end

  // ------------------------------------------------------------
  // event vectors per flag register
  // ------------------------------------------------------------
  // events into flag one
  always_comb
  begin
    ev1 = {psp_access_evt, adc_done_evt, 2'b00, ssp_done_evt,
           ccp1_evt & ~ccp1_pwm_mode, tmr2_match_evt, tmr1_ovf_evt};
  end

  always_comb
  begin
    ev2 = {osc_fail_evt, cmp_change_evt, 1'b0, nv_write_evt,
           bus_coll_evt, volt_trip_evt, tmr3_ovf_evt,
           eccp_evt & ~eccp_pwm_mode};
  end

  always_comb
  begin
    if (r_r.can_mode == ifpb_pkg::CAN_LEGACY)
    begin
      ev3 = {can_invalid_evt, can_wake_evt, can_err_evt,
             can_tx_done_evt, can_rx_new_evt};
    end
    else
    begin
      ev3 = {can_invalid_evt, can_wake_evt, can_err_evt,
             |can_tx_done_evt, 2'b00, |can_rx_new_evt,
             can_watermark_evt};
    end
    // forced-zero bits follow the mode after this edge
    if (mode_nxt == ifpb_pkg::CAN_LEGACY)
      mask3 = 8'hFF;
    else if (mode_nxt == ifpb_pkg::CAN_ENHANCED)
      mask3 = 8'hF2;
    else
      mask3 = 8'hF3;
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always_comb
  begin
    case (adr)
      `IFPB_ADR_PINCTL: rdat = r_r.pinctl;
      `IFPB_ADR_FLAG1: rdat = r_r.flag1;
      `IFPB_ADR_FLAG2: rdat = r_r.flag2;
      `IFPB_ADR_FLAG3: rdat = r_r.flag3;
      `IFPB_ADR_EN1: rdat = r_r.en1;
      `IFPB_ADR_EN2: rdat = r_r.en2;
      `IFPB_ADR_EN3: rdat = r_r.en3;
      `IFPB_ADR_PRIO1: rdat = r_r.prio1;
      `IFPB_ADR_PRIO2: rdat = r_r.prio2;
      `IFPB_ADR_PRIO3: rdat = r_r.prio3;
      `IFPB_ADR_GCTL: rdat = {r_r.gctl[7:2], r_r.can_mode};
      `IFPB_ADR_STAT: rdat = {6'h00, r_r.irq_high, r_r.irq_low};
      default: rdat = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // request routing
  // ------------------------------------------------------------
  // flag and enable per source
  always_comb
  begin
    pin_act[0] = r_r.pinctl[`IFPB_PIN1_FLAG] & r_r.pinctl[`IFPB_PIN1_EN];
    pin_act[1] = r_r.pinctl[`IFPB_PIN2_FLAG] & r_r.pinctl[`IFPB_PIN2_EN];
    act1 = r_r.flag1 & r_r.en1;
    act2 = r_r.flag2 & r_r.en2;
    act3 = r_r.flag3 & r_r.en3;
    any_pin = |pin_act;
    any_per = |act1 | |act2 | |act3;
    any_high = (pin_act[0] & r_r.pinctl[`IFPB_PIN1_PRIO]) |
               (pin_act[1] & r_r.pinctl[`IFPB_PIN2_PRIO]) |
               |(act1 & r_r.prio1) | |(act2 & r_r.prio2) |
               |(act3 & r_r.prio3);
    any_low = (pin_act[0] & ~r_r.pinctl[`IFPB_PIN1_PRIO]) |
              (pin_act[1] & ~r_r.pinctl[`IFPB_PIN2_PRIO]) |
              |(act1 & ~r_r.prio1) | |(act2 & ~r_r.prio2) |
              |(act3 & ~r_r.prio3);
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    r_nxt = r_r;
    // two-flop pin synchroniser, then history for edges
    r_nxt.pin_s1 = {pin2_irq_in, pin1_irq_in};
    r_nxt.pin_s2 = r_r.pin_s1;
    r_nxt.pin_prev = r_r.pin_s2;

    // bus answer one cycle after request, dropped after one cycle
    r_nxt.ack = req & ~r_r.ack;
    r_nxt.dat = (req & ~r_r.ack) ? rdat : 8'h00;

    if (wr_en && adr == `IFPB_ADR_PINCTL)
      r_nxt.pinctl = wd & `IFPB_PINCTL_MASK;
    // pin flags set regardless of enables
    r_nxt.pinctl[`IFPB_PIN1_FLAG] = r_nxt.pinctl[`IFPB_PIN1_FLAG] |
                                    edge_det[0];
    r_nxt.pinctl[`IFPB_PIN2_FLAG] = r_nxt.pinctl[`IFPB_PIN2_FLAG] |
                                    edge_det[1];

    // flag one: writable bits, then events win
    if (wr_en && adr == `IFPB_ADR_FLAG1)
      r_nxt.flag1 = (wd & ~`IFPB_F1_RO_MASK) |
                    (r_r.flag1 & `IFPB_F1_RO_MASK);
    r_nxt.flag1 = r_nxt.flag1 | ev1;
    // receive flag: load sets, buffer read clears
    r_nxt.flag1[`IFPB_F1_RX] = rx_load_evt |
      (r_r.flag1[`IFPB_F1_RX] & ~rx_buf_read);
    // transmit flag: empty sets, buffer write clears
    r_nxt.flag1[`IFPB_F1_TX] = tx_empty_evt |
      (r_r.flag1[`IFPB_F1_TX] & ~tx_buf_write);

    // flag two, unimplemented bit kept zero
    if (wr_en && adr == `IFPB_ADR_FLAG2)
      r_nxt.flag2 = wd;
    r_nxt.flag2 = (r_nxt.flag2 | ev2) & `IFPB_F2_MASK;

    // flag three, forced bits masked by mode
    if (wr_en && adr == `IFPB_ADR_FLAG3)
      r_nxt.flag3 = wd;
    r_nxt.flag3 = (r_nxt.flag3 | ev3) & mask3;

    // enable, priority and global control registers
    if (wr_en && adr == `IFPB_ADR_EN1)
      r_nxt.en1 = wd;
    if (wr_en && adr == `IFPB_ADR_EN2)
      r_nxt.en2 = wd & `IFPB_F2_MASK;
    if (wr_en && adr == `IFPB_ADR_EN3)
      r_nxt.en3 = wd;
    if (wr_en && adr == `IFPB_ADR_PRIO1)
      r_nxt.prio1 = wd;
    if (wr_en && adr == `IFPB_ADR_PRIO2)
      r_nxt.prio2 = wd & `IFPB_F2_MASK;
    if (wr_en && adr == `IFPB_ADR_PRIO3)
      r_nxt.prio3 = wd;
    if (wr_en && adr == `IFPB_ADR_GCTL)
    begin
      r_nxt.gctl = wd & `IFPB_GCTL_MASK;
      r_nxt.can_mode = ifpb_pkg::ifpb_can_mode_type'(wd[1:0]);
    end

    if (r_r.gctl[`IFPB_G_PRIORITY_LEVELS_ENABLE])
    begin
      r_nxt.irq_high = r_r.gctl[`IFPB_G_GIE] & any_high;
      r_nxt.irq_low = r_r.gctl[`IFPB_G_GIE] & r_r.gctl[`IFPB_G_PERIPHERAL_GROUP_ENABLE] &
                      any_low;
    end
    else
    begin
      r_nxt.irq_high = r_r.gctl[`IFPB_G_GIE] &
                       (any_pin | (r_r.gctl[`IFPB_G_PERIPHERAL_GROUP_ENABLE] & any_per));
      r_nxt.irq_low = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      r_r <= '0;
      r_r.pinctl <= `IFPB_PINCTL_RST;
      r_r.gctl <= `IFPB_GCTL_RST;
      r_r.can_mode <= ifpb_pkg::CAN_LEGACY;
    end
    else
      r_r <= r_nxt;
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_pin_flag_set;
    edge_det[0] |=> r_r.pinctl[`IFPB_PIN1_FLAG];
  endproperty
  a_pin_flag_set: assert property (p_pin_flag_set)
    else $error("pin 1 edge did not set its flag");

  property p_poll_no_enable;
    (adc_done_evt && !r_r.en1[6] && !r_r.gctl[`IFPB_G_GIE])
      |=> r_r.flag1[6] && !r_r.irq_high;
  endproperty
  a_poll_no_enable: assert property (p_poll_no_enable)
    else $error("disabled conversion event lost or raised request");

  property p_reserved_zero;
    !r_r.pinctl[5] && !r_r.pinctl[2] && !r_r.flag2[5];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("unimplemented bit became set");

  property p_rx_clear;
    (rx_buf_read && !rx_load_evt) |=> !r_r.flag1[`IFPB_F1_RX];
  endproperty
  a_rx_clear: assert property (p_rx_clear)
    else $error("receive flag not cleared by buffer read");

  property p_tx_clear;
    (tx_buf_write && !tx_empty_evt) |=> !r_r.flag1[`IFPB_F1_TX];
  endproperty
  a_tx_clear: assert property (p_tx_clear)
    else $error("transmit flag not cleared by buffer write");

  property p_psp_sticky;
    (r_r.flag1[`IFPB_F1_PSP] && !(wr_en && adr == `IFPB_ADR_FLAG1))
      |=> r_r.flag1[`IFPB_F1_PSP];
  endproperty
  a_psp_sticky: assert property (p_psp_sticky)
    else $error("parallel port flag dropped without software");

  property p_pwm_unused;
    (ccp1_pwm_mode && !r_r.flag1[`IFPB_F1_CCP] && !wr_en)
      |=> !r_r.flag1[`IFPB_F1_CCP];
  endproperty
  a_pwm_unused: assert property (p_pwm_unused)
    else $error("capture flag set in pwm mode");

  property p_mode_forced;
    (r_r.can_mode != ifpb_pkg::CAN_LEGACY) |->
      !r_r.flag3[`IFPB_F3_TX1] && !r_r.flag3[`IFPB_F3_TX0];
  endproperty
  a_mode_forced: assert property (p_mode_forced)
    else $error("per-buffer transmit flag set outside mode 0");

  property p_gie_blocks;
    !r_r.gctl[`IFPB_G_GIE] |=> !r_r.irq_high ##0 !r_r.irq_low;
  endproperty
  a_gie_blocks: assert property (p_gie_blocks)
    else $error("request raised with global enable clear");

  property p_group_gate;
    (!r_r.gctl[`IFPB_G_PRIORITY_LEVELS_ENABLE] && !r_r.gctl[`IFPB_G_PERIPHERAL_GROUP_ENABLE] && !any_pin)
      |=> !r_r.irq_high;
  endproperty
  a_group_gate: assert property (p_group_gate)
    else $error("peripheral request passed closed group enable");

  property p_ack_pulse;
    r_r.ack |=> !r_r.ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held longer than one cycle");

  property p_osc_set;
    osc_fail_evt |=> r_r.flag2[7];
  endproperty
  a_osc_set: assert property (p_osc_set)
    else $error("oscillator fail event did not set its flag");

  property p_no_low_without_levels;
    !r_r.gctl[`IFPB_G_PRIORITY_LEVELS_ENABLE] |=> !r_r.irq_low;
  endproperty
  a_no_low_without_levels: assert property (p_no_low_without_levels)
    else $error("low request raised with priority levels off");

  c_pin_flag: cover property (edge_det[1] ##1 r_r.pinctl[1]);
  c_irq_high: cover property (!r_r.irq_high ##1 r_r.irq_high);
  c_irq_low: cover property (!r_r.irq_low ##1 r_r.irq_low);
  c_write: cover property (wr_en && adr == `IFPB_ADR_FLAG1);

endmodule

// File: sim/ifpb_src_model.sv
// Purpose: on-chip event sources and pins beside the flag bank
// Assumes: the bench raises fire bits for the events it wants
// Notes: every event leaves as one clean single-cycle pulse
`timescale 1ns/1ps

module ifpb_src_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic [26:0] fire,
  input wire logic [1:0] pin_lvl,
  output logic [26:0] evt,
  output logic [1:0] pin_o
);
  // pulse shaping, a held request never stretches a pulse
  always_ff @(posedge clk)
  begin
    if (srst)
      evt <= '0;
    else
      evt <= fire & ~evt;
  end

  // external pins are plain levels
  assign pin_o = pin_lvl;
endmodule

// File: sim/tb_interrupt_flag_priority_bank.sv
// Purpose: self-checking bench for the interrupt flag bank
// Assumes: event vector bits follow the flag register bit order
// Notes: random values come from a fixed seed
`timescale 1ns/1ps
`include "ifpb_defs.svh"

module tb_interrupt_flag_priority_bank;
  logic clk, srst, cyc, we;
  logic [7:0] adr, g, pc;
  logic [31:0] wdat, dat_o, rdat;
  logic ack, irq_high, irq_low, en, pr;
  logic [26:0] fire, ev, v;
  logic [1:0] pin_lvl, pins, pwm, x;
  logic [3:0] sel, sel_v;
  int error_cnt, compares, cycles, i, p, e, m;

  ifpb_src_model ifpb_src_model_inst (.clk(clk), .srst(srst),
    .fire(fire), .pin_lvl(pin_lvl), .evt(ev), .pin_o(pins));

  ifpb_top ifpb_top_inst (.clk(clk), .srst(srst), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .pin1_irq_in(pins[0]), .pin2_irq_in(pins[1]),
    .psp_access_evt(ev[7]), .adc_done_evt(ev[6]), .rx_load_evt(ev[5]),
    .rx_buf_read(ev[24]), .tx_empty_evt(ev[4]), .tx_buf_write(ev[25]),
    .ssp_done_evt(ev[3]), .ccp1_evt(ev[2]), .ccp1_pwm_mode(pwm[0]),
    .tmr2_match_evt(ev[1]), .tmr1_ovf_evt(ev[0]), .osc_fail_evt(ev[15]),
    .cmp_change_evt(ev[14]), .nv_write_evt(ev[12]),
    .bus_coll_evt(ev[11]), .volt_trip_evt(ev[10]), .tmr3_ovf_evt(ev[9]),
    .eccp_evt(ev[8]), .eccp_pwm_mode(pwm[1]), .can_invalid_evt(ev[23]),
    .can_wake_evt(ev[22]), .can_err_evt(ev[21]),
    .can_tx_done_evt(ev[20:18]), .can_rx_new_evt(ev[17:16]),
    .can_watermark_evt(ev[26]), .irq_high(irq_high), .irq_low(irq_low));

  // free-running clock, 25 ns period
  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  // compare and count
  task automatic chk(input string nm, input logic [31:0] got, exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, d);
    @(posedge clk);
    cyc <= 1'h1;
    we <= w;
    sel <= sel_v;
    adr <= a;
    wdat <= {24'h000000, d};
    @(posedge clk);
    // ack ends this wait, the hang guard only if ack never comes
    while (ack !== 1'h1)
      @(posedge clk);
    rdat = dat_o;
    cyc <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, e, input string nm);
    wb(1'h0, a, 8'h00);
    chk(nm, rdat, {24'h000000, e});
  endtask

  task automatic fire_evt(input logic [26:0] f);
    @(posedge clk);
    fire <= f;
    @(posedge clk);
    fire <= '0;
    repeat (3) @(posedge clk);
  endtask

  // third flag register layout per mode
  function automatic logic [7:0] f3_exp(input int md, input logic [7:0] s,
                                        input logic wm);
    if (md == 0)
      return s;
    return {s[7:5], |s[4:2], 2'h0, |s[1:0], (md == 2) & wm};
  endfunction

  // request routing, first peripheral flag held set
  function automatic logic [1:0] irq_exp(input logic [7:0] gc, pcv,
                                         input logic en_b, pr_b);
    logic qa;
    qa = pcv[0] & pcv[3];
    if (!gc[3])
      return {gc[7] & (qa | gc[6] & en_b), 1'h0};
    return {gc[7] & (qa & pcv[6] | en_b & pr_b),
            gc[7] & gc[6] & (qa & ~pcv[6] | en_b & ~pr_b)};
  endfunction

  task automatic give_verdict();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      error_cnt++;
      give_verdict();
    end
  end

  // main sequence
  initial
  begin
    srst = 1'h1; cyc = 1'h0; we = 1'h0; adr = 8'h00; wdat = '0;
    fire = '0; pin_lvl = 2'h0; pwm = 2'h0; cycles = 0;
    sel = 4'h0;
    sel_v = 4'hF;
    error_cnt = 0; compares = 0;
    repeat (16) @(posedge clk);
    srst <= 1'h0;
    void'($urandom(62));
    // reset values, reserved and read-only bits
    rd(`IFPB_ADR_PINCTL, 8'hC0, "pinctl reset");
    rd(`IFPB_ADR_GCTL, 8'h30, "gctl reset");
    for (i = 1; i < 10; i++)
      rd(8'(4 * i), 8'h00, "zero reset");
    // write without the low byte lane is ignored
    sel_v = 4'hE;
    wb(1'h1, `IFPB_ADR_PINCTL, 8'hFF);
    sel_v = 4'hF;
    rd(`IFPB_ADR_PINCTL, 8'hC0, "sel lane off");
    wb(1'h1, `IFPB_ADR_PINCTL, 8'hFF);
    rd(`IFPB_ADR_PINCTL, 8'hDB, "pinctl reserved");
    wb(1'h1, `IFPB_ADR_PINCTL, 8'hC0);
    wb(1'h1, `IFPB_ADR_FLAG2, 8'hFF);
    rd(`IFPB_ADR_FLAG2, 8'hDF, "flag2 reserved");
    wb(1'h1, `IFPB_ADR_FLAG1, 8'hFF);
    rd(`IFPB_ADR_FLAG1, 8'hCF, "flag1 read-only");
    wb(1'h1, `IFPB_ADR_FLAG1, 8'h00);
    wb(1'h1, `IFPB_ADR_FLAG2, 8'h00);
    wb(1'h1, 8'h30, 8'hAA);
    rd(8'h30, 8'h00, "unmapped");
    $display("test access done");
    // single events first, then random mixes, all enables off
    for (i = 0; i < 28; i++)
    begin
      v = (i < 16) ? 27'(27'h1 << i) : 27'($urandom()) & 27'h00DFFF;
      fire_evt(v);
      rd(`IFPB_ADR_FLAG1, v[7:0], "flag1 set");
      rd(`IFPB_ADR_FLAG2, v[15:8] & 8'hDF, "flag2 set");
      wb(1'h1, `IFPB_ADR_FLAG1, 8'h00);
      wb(1'h1, `IFPB_ADR_FLAG2, 8'h00);
      rd(`IFPB_ADR_FLAG1, v[7:0] & 8'h30, "flag1 sw clear");
      rd(`IFPB_ADR_FLAG2, 8'h00, "flag2 sw clear");
      fire_evt(27'h3000000);
      rd(`IFPB_ADR_FLAG1, 8'h00, "buffer access clear");
    end
    pwm <= 2'h3;
    fire_evt(27'h0000104);
    rd(`IFPB_ADR_FLAG1, 8'h00, "pwm capture unit");
    rd(`IFPB_ADR_FLAG2, 8'h00, "pwm enhanced unit");
    pwm <= 2'h0;
    $display("test peripheral flags done");
    // third register in modes 0, 1 and 2
    for (i = 0; i < 15; i++)
    begin
      m = i % 3;
      v = (i < 3) ? 27'h4FF0000 : 27'($urandom());
      v[26] = v[26] & (m != 0);
      wb(1'h1, `IFPB_ADR_GCTL, 8'h30 | 8'(m));
      fire_evt({v[26], 2'h0, v[23:16], 16'h0000});
      rd(`IFPB_ADR_FLAG3, f3_exp(m, v[23:16], v[26]), "flag3");
      wb(1'h1, `IFPB_ADR_GCTL, 8'h30);
      wb(1'h1, `IFPB_ADR_FLAG3, 8'h00);
      rd(`IFPB_ADR_FLAG3, 8'h00, "flag3 clear");
    end
    $display("test can flags done");
    // pins, both edge selections
    for (i = 0; i < 4; i++)
    begin
      p = i / 2;
      e = i % 2;
      g = (e == 0) ? 8'h00 : ((p == 1) ? 8'h10 : 8'h20);
      wb(1'h1, `IFPB_ADR_GCTL, g);
      pin_lvl[p] <= 1'(~e);
      repeat (8) @(posedge clk);
      wb(1'h1, `IFPB_ADR_PINCTL, 8'hC0);
      pin_lvl[p] <= 1'(e);
      repeat (8) @(posedge clk);
      rd(`IFPB_ADR_PINCTL, 8'hC0 | 8'(1 << p), "pin flag");
      wb(1'h1, `IFPB_ADR_PINCTL, 8'hC0);
      pin_lvl[p] <= 1'(~e);
      repeat (8) @(posedge clk);
      rd(`IFPB_ADR_PINCTL, 8'hC0, "other edge");
    end
    $display("test pins done");
    wb(1'h1, `IFPB_ADR_FLAG1, 8'h00);
    fire_evt(27'h0000001);
    for (i = 0; i < 32; i++)
    begin
      g = (8'($urandom()) & 8'hC8) | 8'h30;
      pc = 8'($urandom()) & 8'hC9;
      en = 1'($urandom());
      pr = 1'($urandom());
      wb(1'h1, `IFPB_ADR_PINCTL, pc);
      wb(1'h1, `IFPB_ADR_EN1, {7'h00, en});
      wb(1'h1, `IFPB_ADR_PRIO1, {7'h00, pr});
      wb(1'h1, `IFPB_ADR_GCTL, g);
      repeat (2) @(posedge clk);
      @(negedge clk);
      x = irq_exp(g, pc, en, pr);
      chk("irq lines", {irq_high, irq_low}, x);
      rd(`IFPB_ADR_STAT, {6'h00, x}, "status");
    end
    $display("test routing done");
    give_verdict();
  end
endmodule
